// ==== ccpt_pkg.sv ====
/*
  ccpt_pkg: register offsets, field positions, reset values, mode codes and
  carrier structs for the capture/compare channel with its period timer.
  assumes byte-wide registers on a 32-bit classic wishbone bus, index*4.
*/
package ccpt_pkg;
  // register indices; byte address is index * 4
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_PT_COUNT = 8'h11;
  localparam logic [7:0] IDX_PT_CONTROL = 8'h12;
  localparam logic [7:0] IDX_CC_LOW = 8'h15;
  localparam logic [7:0] IDX_CC_HIGH = 8'h16;
  localparam logic [7:0] IDX_CH_CONTROL = 8'h17;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_PT_LIMIT = 8'h92;
  localparam logic [7:0] IDX_REF_LOW = 8'h0e;
  localparam logic [7:0] IDX_REF_HIGH = 8'h0f;
  // field positions
  localparam int FLG_REF_OVF = 0;
  localparam int FLG_PERIOD = 1;
  localparam int FLG_CHANNEL = 2;
  localparam int PTC_RUN = 2;
  localparam int PTC_POST_LO = 3;
  localparam int PTC_POST_HI = 6;
  localparam int CHC_DUTY_LO = 4;
  localparam int CHC_DUTY_HI = 5;
  // reset values and masks
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
  localparam logic [7:0] RST_PT_COUNT = 8'h00;
  localparam logic [7:0] RST_PT_CONTROL = 8'h00;
  localparam logic [7:0] RST_PT_LIMIT = 8'hff;
  localparam logic [7:0] RST_CH_CONTROL = 8'h00;
  localparam logic [7:0] MSK_PT_CONTROL = 8'h7f;
  localparam logic [7:0] MSK_CH_CONTROL = 8'h3f;
  localparam logic [7:0] MSK_IRQ = 8'hc7;
  // prescale terminal counts (count of cycles or capture edges minus one)
  localparam logic [3:0] PRE_DIV1_LAST = 4'h0;
  localparam logic [3:0] PRE_DIV4_LAST = 4'h3;
  localparam logic [3:0] PRE_DIV16_LAST = 4'hf;
  localparam logic [3:0] CAP_EDGE4_LAST = 4'h3;
  localparam logic [3:0] CAP_EDGE16_LAST = 4'hf;
  // channel mode codes
  typedef enum logic [3:0] {
    CCPT_OFF = 4'h0,
    CCPT_CAP_FALL = 4'h4,
    CCPT_CAP_RISE = 4'h5,
    CCPT_CAP_RISE4 = 4'h6,
    CCPT_CAP_RISE16 = 4'h7,
    CCPT_CMP_HIGH = 4'h8,
    CCPT_CMP_LOW = 4'h9,
    CCPT_CMP_SOFT = 4'ha,
    CCPT_CMP_SPECIAL = 4'hb
  } ccpt_mode_e;
  // events toward the rest of the device
  typedef struct packed {
    logic period_match;
    logic ref_reset;
    logic adc_start;
  } ccpt_evt_s;
endpackage

// ==== ccpt_top.sv ====
/*
  ccpt_top: one capture/compare channel, its period timer with prescaler
  and postscaler, and the register file behind a classic wishbone slave.
  assumes the reference counter value arrives synchronous to clk_i, and the
  pin input is a plain level from the pad, synchronised here.
*/
`timescale 1ns/100ps
// Summary of operation
// - pre/post counters clear on count, control writes, reset
// - control write leaves period count untouched
// - pre-postscaler match pulse goes to serial port
// - postscale divides matches by field plus one
// - prescale divides by 1, 4 or 16
// - count to limit, then wrap to zero
// - postscaled match sets period match flag
// - control bits 5:4 hold duty low bits
// - mode codes: off, capture fall/rise/4th/16th
// - compare high, low, soft, special; PWM codes
// - capture copies 16-bit reference counter value
// - capture sets channel flag; software clears
// - new capture overwrites unread value
// - edge prescaler clears when not capturing
// - switching capture prescale keeps edge counter
// - mode change may set channel flag
// - compare each cycle, act on equality
// - zero control forces compare latch low
// - special event resets counter, starts conversion
// - special event never sets overflow flag
module ccpt_top #(
  parameter int ADR_W = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // reference counter side
  input wire logic [15:0] ref_count_i,
  input wire logic ref_overflow_i,
  // channel pin
  input wire logic channel_pin_i,
  output logic channel_pin_o,
  // events to other blocks
  output ccpt_pkg::ccpt_evt_s evt_o,
  output logic [7:0] irq_flags_o,
  output logic [7:0] irq_enables_o
);
  logic [7:0] flags_r;
  logic [7:0] enables_r;
  logic [7:0] pt_count_r;
  logic [7:0] pt_control_r;
  logic [7:0] pt_limit_r;
  logic [7:0] ch_control_r;
  logic [7:0] cc_low_r;
  logic [7:0] cc_high_r;
  logic [3:0] pre_cnt_r;
  logic [3:0] post_cnt_r;
  logic [3:0] edge_cnt_r;
  logic pin_meta_r;
  logic pin_sync_r;
  logic pin_prev_r;
  logic cmp_latch_r;
  logic ack_r;
  logic err_r;
  logic [31:0] dat_r;
  ccpt_pkg::ccpt_evt_s evt_r;

  // register index decoding, used for reads and for write strobes
  function automatic logic [7:0] word_index(input logic [ADR_W-1:0] a);
    word_index = 8'(a >> 2);
  endfunction

  function automatic logic is_mapped(input logic [7:0] i);
    case (i)
      ccpt_pkg::IDX_IRQ_FLAGS, ccpt_pkg::IDX_PT_COUNT, ccpt_pkg::IDX_PT_CONTROL,
      ccpt_pkg::IDX_CC_LOW, ccpt_pkg::IDX_CC_HIGH, ccpt_pkg::IDX_CH_CONTROL,
      ccpt_pkg::IDX_IRQ_ENABLES, ccpt_pkg::IDX_PT_LIMIT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  logic [7:0] idx;
  logic req;
  logic wr;
  logic wr_flags;
  logic wr_enables;
  logic wr_count;
  logic wr_ptctl;
  logic wr_limit;
  logic wr_chctl;
  logic wr_low;
  logic wr_high;
  assign idx = word_index(adr_i);
  assign req = cyc_i && stb_i && !ack_r && !err_r;
  assign wr = req && we_i && sel_i[0] && is_mapped(idx);
  assign wr_flags = wr && (idx == ccpt_pkg::IDX_IRQ_FLAGS);
  assign wr_enables = wr && (idx == ccpt_pkg::IDX_IRQ_ENABLES);
  assign wr_count = wr && (idx == ccpt_pkg::IDX_PT_COUNT);
  assign wr_ptctl = wr && (idx == ccpt_pkg::IDX_PT_CONTROL);
  assign wr_limit = wr && (idx == ccpt_pkg::IDX_PT_LIMIT);
  assign wr_chctl = wr && (idx == ccpt_pkg::IDX_CH_CONTROL);
  assign wr_low = wr && (idx == ccpt_pkg::IDX_CC_LOW);
  assign wr_high = wr && (idx == ccpt_pkg::IDX_CC_HIGH);

  // mode decoding
  ccpt_pkg::ccpt_mode_e mode;
  logic is_capture;
  logic is_compare;
  logic is_pwm;
  assign mode = ccpt_pkg::ccpt_mode_e'(ch_control_r[3:0]);
  assign is_capture = (ch_control_r[3:2] == 2'b01);
  assign is_compare = (ch_control_r[3:2] == 2'b10);
  assign is_pwm = (ch_control_r[3:2] == 2'b11);

  // period timer tick and match
  logic [3:0] pre_last;
  logic pre_tick;
  logic pt_match;
  logic post_tick;
  always_comb
  begin
    case (pt_control_r[1:0])
      2'b00: pre_last = ccpt_pkg::PRE_DIV1_LAST;
      2'b01: pre_last = ccpt_pkg::PRE_DIV4_LAST;
      default: pre_last = ccpt_pkg::PRE_DIV16_LAST;
    endcase
  end
  assign pre_tick = pt_control_r[ccpt_pkg::PTC_RUN] && (pre_cnt_r >= pre_last);
  assign pt_match = pre_tick && (pt_count_r == pt_limit_r);
  assign post_tick = pt_match &&
    (post_cnt_r >= pt_control_r[ccpt_pkg::PTC_POST_HI:ccpt_pkg::PTC_POST_LO]);

  // capture edge detection on the synchronised pin
  logic rise;
  logic fall;
  logic [3:0] edge_last;
  logic cap_event;
  assign rise = pin_sync_r && !pin_prev_r;
  assign fall = !pin_sync_r && pin_prev_r;
  always_comb
  begin
    case (mode)
      ccpt_pkg::CCPT_CAP_RISE4: edge_last = ccpt_pkg::CAP_EDGE4_LAST;
      ccpt_pkg::CCPT_CAP_RISE16: edge_last = ccpt_pkg::CAP_EDGE16_LAST;
      default: edge_last = 4'h0;
    endcase
  end
  always_comb
  begin
    case (mode)
      ccpt_pkg::CCPT_CAP_FALL: cap_event = fall;
      ccpt_pkg::CCPT_CAP_RISE: cap_event = rise;
      ccpt_pkg::CCPT_CAP_RISE4, ccpt_pkg::CCPT_CAP_RISE16:
        cap_event = rise && (edge_cnt_r >= edge_last);
      default: cap_event = 1'b0;
    endcase
  end

  // compare against reference counter every cycle
  logic cmp_hit;
  logic special;
  assign cmp_hit = is_compare && (ref_count_i == {cc_high_r, cc_low_r});
  assign special = cmp_hit && (mode == ccpt_pkg::CCPT_CMP_SPECIAL);

  // pin synchroniser and edge history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end
    else
    begin
      pin_meta_r <= channel_pin_i;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // capture edge prescale counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !is_capture)
      edge_cnt_r <= 4'h0;
    else if (rise && (edge_last != 4'h0))
      edge_cnt_r <= (edge_cnt_r >= edge_last) ? 4'h0 : edge_cnt_r + 4'h1;
  end

  // period timer prescaler
  always_ff @(posedge clk_i)
  begin
    if (rst_i || wr_count || wr_ptctl)
      pre_cnt_r <= 4'h0;
    else if (pt_control_r[ccpt_pkg::PTC_RUN])
      pre_cnt_r <= pre_tick ? 4'h0 : pre_cnt_r + 4'h1;
  end

  // period timer postscaler
  always_ff @(posedge clk_i)
  begin
    if (rst_i || wr_count || wr_ptctl)
      post_cnt_r <= 4'h0;
    else if (pt_match)
      post_cnt_r <= post_tick ? 4'h0 : post_cnt_r + 4'h1;
  end

  // period timer count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pt_count_r <= ccpt_pkg::RST_PT_COUNT;
    else if (wr_count)
      pt_count_r <= dat_i[7:0];
    else if (pt_match)
      pt_count_r <= 8'h00;
    else if (pre_tick)
      pt_count_r <= pt_count_r + 8'h01;
  end

  // period timer control and limit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pt_control_r <= ccpt_pkg::RST_PT_CONTROL;
      pt_limit_r <= ccpt_pkg::RST_PT_LIMIT;
    end
    else
    begin
      if (wr_ptctl)
        pt_control_r <= dat_i[7:0] & ccpt_pkg::MSK_PT_CONTROL;
      if (wr_limit)
        pt_limit_r <= dat_i[7:0];
    end
  end

  // channel control, mode and duty low bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ch_control_r <= ccpt_pkg::RST_CH_CONTROL;
    else if (wr_chctl)
      ch_control_r <= dat_i[7:0] & ccpt_pkg::MSK_CH_CONTROL;
  end

  // capture/compare value; capture overwrites unconditionally
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cc_low_r <= 8'h00;
      cc_high_r <= 8'h00;
    end
    else if (cap_event)
    begin
      cc_low_r <= ref_count_i[7:0];
      cc_high_r <= ref_count_i[15:8];
    end
    else
    begin
      if (wr_low)
        cc_low_r <= dat_i[7:0];
      if (wr_high && !is_pwm)
        cc_high_r <= dat_i[7:0];
    end
  end

  // compare output latch
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ch_control_r[3:0] == 4'h0))
      cmp_latch_r <= 1'b0;
    else if (cmp_hit && (mode == ccpt_pkg::CCPT_CMP_HIGH))
      cmp_latch_r <= 1'b1;
    else if (cmp_hit && (mode == ccpt_pkg::CCPT_CMP_LOW))
      cmp_latch_r <= 1'b0;
  end

  // interrupt flags: hardware set wins over a software write
  logic [7:0] flags_nxt;
  always_comb
  begin
    flags_nxt = wr_flags ? (dat_i[7:0] & ccpt_pkg::MSK_IRQ) : flags_r;
    if (post_tick)
      flags_nxt[ccpt_pkg::FLG_PERIOD] = 1'b1;
    if (cap_event || cmp_hit)
      flags_nxt[ccpt_pkg::FLG_CHANNEL] = 1'b1;
    if (ref_overflow_i && !special)
      flags_nxt[ccpt_pkg::FLG_REF_OVF] = 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags_r <= ccpt_pkg::RST_IRQ_FLAGS;
      enables_r <= ccpt_pkg::RST_IRQ_ENABLES;
    end
    else
    begin
      flags_r <= flags_nxt;
      if (wr_enables)
        enables_r <= dat_i[7:0] & ccpt_pkg::MSK_IRQ;
    end
  end

  // events to other blocks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_r <= '0;
    else
    begin
      evt_r.period_match <= pt_match;
      evt_r.ref_reset <= special;
      evt_r.adc_start <= special;
    end
  end

  // wishbone answer: one wait state, ack or err for one cycle
  logic [7:0] rd_byte;
  always_comb
  begin
    case (idx)
      ccpt_pkg::IDX_IRQ_FLAGS: rd_byte = flags_r;
      ccpt_pkg::IDX_IRQ_ENABLES: rd_byte = enables_r;
      ccpt_pkg::IDX_PT_COUNT: rd_byte = pt_count_r;
      ccpt_pkg::IDX_PT_CONTROL: rd_byte = pt_control_r;
      ccpt_pkg::IDX_PT_LIMIT: rd_byte = pt_limit_r;
      ccpt_pkg::IDX_CH_CONTROL: rd_byte = ch_control_r;
      ccpt_pkg::IDX_CC_LOW: rd_byte = cc_low_r;
      ccpt_pkg::IDX_CC_HIGH: rd_byte = cc_high_r;
      default: rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h0;
    end
    else
    begin
      ack_r <= req && is_mapped(idx);
      err_r <= req && !is_mapped(idx);
      dat_r <= {24'h0, rd_byte};
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign err_o = err_r;
  assign channel_pin_o = cmp_latch_r;
  assign evt_o = evt_r;
  assign irq_flags_o = flags_r;
  assign irq_enables_o = enables_r;
endmodule

// ==== ccpt_ref_model.sv ====
/*
  ccpt_ref_model: far-side model of the reference counter feeding the channel.
  assumes one clock, synchronous active-high reset, bench-controlled load.
*/
`timescale 1ns/100ps
module ccpt_ref_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench control
  input wire logic run_i,
  input wire logic load_i,
  input wire logic [15:0] load_val_i,
  // trigger from channel
  input wire logic ref_reset_i,
  // counter
  output logic [15:0] ref_count_o,
  output logic ref_overflow_o
);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ref_count_o <= 16'h0000;
    else if (load_i)
      ref_count_o <= load_val_i;
    else if (ref_reset_i)
      ref_count_o <= 16'h0000;
    else if (run_i)
      ref_count_o <= ref_count_o + 16'h0001;
  end
  // trigger reset never raises overflow
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ref_overflow_o <= 1'b0;
    else
      ref_overflow_o <= run_i && !load_i && !ref_reset_i &&
        (ref_count_o == 16'hffff);
  end
endmodule

// ==== ccpt_top_props.sv ====
/*
  ccpt_top_props: port-level checker for ccpt_top, bound below.
  assumes byte index * 4 addressing and one clock domain.
*/
`timescale 1ns/100ps
module ccpt_top_props #(
  parameter int ADR_W = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [15:0] ref_count_i,
  input wire logic ref_overflow_i,
  input wire logic channel_pin_i,
  input wire logic channel_pin_o,
  input wire ccpt_pkg::ccpt_evt_s evt_o,
  input wire logic [7:0] irq_flags_o,
  input wire logic [7:0] irq_enables_o
);
  logic wr;
  logic wf;
  logic wc;
  logic mt;
  logic [3:0] mode_r;
  logic [15:0] cc_r;
  assign wr = cyc_i && stb_i && !ack_o && !err_o && we_i && sel_i[0];
  assign wf = wr && adr_i == ADR_W'({ccpt_pkg::IDX_IRQ_FLAGS, 2'b00});
  assign wc = wr && adr_i == ADR_W'({ccpt_pkg::IDX_CH_CONTROL, 2'b00});
  assign mt = cc_r == ref_count_i && mode_r[3:2] == 2'b10;
  // shadow of mode and compare value from bus writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_r <= 4'h0;
    else if (wc)
      mode_r <= dat_i[3:0];
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cc_r <= 16'h0000;
    else if (wr && adr_i == ADR_W'({ccpt_pkg::IDX_CC_LOW, 2'b00}))
      cc_r[7:0] <= dat_i[7:0];
    else if (wr && adr_i == ADR_W'({ccpt_pkg::IDX_CC_HIGH, 2'b00}))
      cc_r[15:8] <= dat_i[7:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    $rose(cyc_i && stb_i);
  endsequence
  sequence ans_s;
    (ack_o ^ err_o) ##1 !(ack_o || err_o);
  endsequence
  AST_ANSWER: assert property (req_s |=> ans_s)
    else $error("bus answer not a single pulse");
  AST_CH_FLAG_HOLD: assert property (irq_flags_o[2] && !wf |=> irq_flags_o[2])
    else $error("channel flag cleared by hardware");
  AST_OVF_SOURCE: assert property ($rose(irq_flags_o[0]) |->
    $past(ref_overflow_i) || $past(wf))
    else $error("overflow flag without overflow");
  AST_CMP_SET: assert property (mt && mode_r[1:0] == 2'b00 && !wc |=> channel_pin_o)
    else $error("pin not driven high on match");
  AST_CMP_CLR: assert property (mt && mode_r[1:0] == 2'b01 && !wc |=> !channel_pin_o)
    else $error("pin not driven low on match");
  AST_CMP_FLAG: assert property (mt |=> irq_flags_o[2])
    else $error("match did not set channel flag");
  AST_CMP_KEEP: assert property (mode_r == 4'ha && !wc |=> $stable(channel_pin_o))
    else $error("pin moved in flag-only compare");
  AST_TRIGGER: assert property (mt && mode_r == 4'hb |=>
    evt_o.ref_reset && evt_o.adc_start)
    else $error("special trigger missing");
  AST_ZERO_LOW: assert property (wc && dat_i[7:0] == 8'h00 |-> ##2 !channel_pin_o)
    else $error("zero control left pin high");
endmodule
bind ccpt_top ccpt_top_props #(.ADR_W(ADR_W)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .ref_count_i(ref_count_i),
  .ref_overflow_i(ref_overflow_i), .channel_pin_i(channel_pin_i),
  .channel_pin_o(channel_pin_o), .evt_o(evt_o), .irq_flags_o(irq_flags_o),
  .irq_enables_o(irq_enables_o));

// ==== testbench.sv ====
/*
  testbench: self-checking bench for ccpt_top with a reference counter model.
  assumes a classic wishbone answer in one cycle and 100 MHz clock.
*/
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic pin_i = 1'b0;
  logic run = 1'b0;
  logic load = 1'b0;
  logic [15:0] load_val = 16'h0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic err_o;
  logic pin_o;
  logic ref_ovf;
  logic [15:0] ref_count;
  logic [7:0] flags;
  logic [7:0] enables;
  logic [7:0] rd;
  logic bus_err;
  ccpt_pkg::ccpt_evt_s evt_o;
  int miscompares = 0;
  int checked = 0;
  int pm_n = 0;
  int trig_n = 0;
  always #5 clk_i = ~clk_i;
  ccpt_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .ref_count_i(ref_count), .ref_overflow_i(ref_ovf), .channel_pin_i(pin_i),
    .channel_pin_o(pin_o), .evt_o(evt_o), .irq_flags_o(flags), .irq_enables_o(enables));
  ccpt_ref_model far (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .load_i(load),
    .load_val_i(load_val), .ref_reset_i(evt_o.ref_reset), .ref_count_o(ref_count),
    .ref_overflow_o(ref_ovf));
  always @(posedge clk_i)
  begin
    if (evt_o.period_match)
      pm_n++;
    if (evt_o.ref_reset && evt_o.adc_start)
      trig_n++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'h1;
    adr_i <= {ix, 2'b00};
    dat_i <= {24'h000000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_i);
    end
    chk(16'(n < 20), 16'h0001);
    rd = dat_o[7:0];
    bus_err = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] ix, input logic [7:0] exp);
    wb(1'b0, ix, 8'h00);
    chk(16'(rd), 16'(exp));
  endtask
  task automatic ld(input logic [15:0] v);
    load_val <= v;
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
  endtask
  task automatic pulse;
    pin_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    pin_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic t_regs;
    logic [47:0] ix;
    logic [47:0] ex;
    ix = 48'h0c1112178c92;
    ex = 48'h0000000000ff;
    for (int i = 0; i < 6; i++)
      rchk(ix[i*8+:8], ex[i*8+:8]);
    wb(1'b0, 8'h00, 8'h00);
    chk(16'(bus_err), 16'h0001);
    wb(1'b1, 8'h8c, 8'h04);
    chk(16'(enables), 16'h0004);
    wb(1'b1, 8'h17, 8'hf0);
    rchk(8'h17, 8'h30);
    $display("test regs done");
  endtask
  task automatic t_timer;
    wb(1'b1, 8'h11, 8'h02);
    wb(1'b1, 8'h12, 8'h01);
    rchk(8'h11, 8'h02);
    wb(1'b1, 8'h92, 8'h03);
    wb(1'b1, 8'h11, 8'h00);
    wb(1'b1, 8'h12, 8'h05);
    pm_n = 0;
    repeat (160) @(posedge clk_i);
    chk(16'(pm_n > 8 && pm_n < 12), 16'h0001);
    wb(1'b1, 8'h12, 8'h7c);
    wb(1'b1, 8'h0c, 8'h00);
    repeat (30) @(posedge clk_i);
    rchk(8'h0c, 8'h00);
    repeat (40) @(posedge clk_i);
    rchk(8'h0c, 8'h02);
    wb(1'b1, 8'h12, 8'h00);
    $display("test timer done");
  endtask
  task automatic t_cap;
    logic [15:0] md;
    logic [15:0] v;
    int ne [4] = '{1, 1, 4, 16};
    md = 16'h7654;
    for (int i = 0; i < 4; i++)
    begin
      v = {4'(i), 12'h5a3};
      ld(v);
      wb(1'b1, 8'h17, 8'h00);
      wb(1'b1, 8'h17, {4'h0, md[i*4+:4]});
      wb(1'b1, 8'h0c, 8'h00);
      repeat (ne[i] - 1) pulse();
      rchk(8'h0c, 8'h00);
      pulse();
      rchk(8'h0c, 8'h04);
      chk(16'(flags), 16'h0004);
      rchk(8'h15, v[7:0]);
      rchk(8'h16, v[15:8]);
    end
    wb(1'b1, 8'h0c, 8'h00);
    repeat (3) pulse();
    wb(1'b1, 8'h17, 8'h06);
    pulse();
    rchk(8'h0c, 8'h04);
    wb(1'b1, 8'h17, 8'h05);
    ld(16'h0abc);
    pulse();
    ld(16'hc0de);
    pulse();
    rchk(8'h15, 8'hde);
    rchk(8'h16, 8'hc0);
    $display("test capture done");
  endtask
  task automatic t_cmp;
    logic [19:0] md;
    logic [4:0] pv;
    int n;
    md = 20'h8b9a8;
    pv = 5'b10011;
    wb(1'b1, 8'h17, 8'h00);
    wb(1'b1, 8'h15, 8'h40);
    wb(1'b1, 8'h16, 8'h10);
    run <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b1, 8'h17, {4'h0, md[i*4+:4]});
      wb(1'b1, 8'h0c, 8'h00);
      ld(16'h1020);
      n = 0;
      while (ref_count !== 16'h1040 && n < 100)
      begin
        n++;
        @(posedge clk_i);
      end
      chk(16'(n < 100), 16'h0001);
      repeat (3) @(posedge clk_i);
      chk(16'(pin_o), 16'(pv[i]));
      rchk(8'h0c, 8'h04);
    end
    wb(1'b1, 8'h17, 8'h00);
    repeat (3) @(posedge clk_i);
    chk(16'(pin_o), 16'h0000);
    chk(16'(trig_n), 16'h0001);
    wb(1'b1, 8'h0c, 8'h00);
    ld(16'hfffd);
    repeat (6) @(posedge clk_i);
    rchk(8'h0c, 8'h01);
    run <= 1'b0;
    $display("test compare done");
  endtask
  task automatic print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_timer();
    t_cap();
    t_cmp();
    print_verdict();
  end
  initial
  begin
    #200000;
    miscompares++;
    print_verdict();
  end
endmodule
